// ==== design/free_and_modulus_counter_pkg.sv ====
// Constants, field layouts and carrier types for the counter block.
// Assumes a single 25 MHz system clock and a 16-bit register port.
`default_nettype none

package free_and_modulus_counter_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 25000000;
    // External count pin may toggle at up to a quarter of this rate
    localparam int EXT_RATE_DIVISOR = 4;
    localparam int PRESC_WIDTH = 6;

    // ------------------------------------------------------------
    // Register indices (word addresses on the register port)
    // ------------------------------------------------------------
    localparam logic [2:0] REG_FREE_CTL = 3'h0;
    localparam logic [2:0] REG_FREE_CNT = 3'h1;
    localparam logic [2:0] REG_MOD_CTL = 3'h2;
    localparam logic [2:0] REG_MOD_CNT = 3'h3;
    localparam logic [2:0] REG_MOD_LATCH = 3'h4;
    localparam logic [2:0] REG_CONFIG = 3'h5;

    // Status/control bit positions
    localparam int CTL_COF_BIT = 15;
    localparam int CTL_PIN_BIT = 14;
    localparam int CTL_ARBHI_BIT = 13;
    localparam int CTL_LOADPIN_BIT = 12;
    localparam int CTL_LEVEL_LSB = 8;
    localparam int CTL_BUS_DRIVE_SELECT_B_BIT = 7;
    localparam int CTL_BUS_DRIVE_SELECT_A_BIT = 6;
    localparam int CTL_LOADEDGE_LSB = 4;
    localparam int CTL_CLKSEL_LSB = 0;

    // Module configuration bit positions
    localparam int CFG_VECT_LSB = 6;
    localparam int CFG_FRZ_BIT = 4;
    localparam int CFG_RUN_BIT = 3;
    localparam int CFG_ARB_LSB = 0;

    // Unit numbers that form the low vector bits
    localparam logic [5:0] FREE_UNIT_NUM = 6'h0c;
    localparam logic [5:0] MOD_UNIT_NUM = 6'h0b;

    // Pin indices in the synchroniser vectors
    localparam int PIN_FREE_COUNT = 0;
    localparam int PIN_MOD_COUNT = 1;
    localparam int PIN_MOD_LOAD = 2;

    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CLK_TAP1 = 3'b000,
        CLK_TAP2 = 3'b001,
        CLK_TAP3 = 3'b010,
        CLK_TAP4 = 3'b011,
        CLK_TAP5 = 3'b100,
        CLK_TAP6 = 3'b101,
        CLK_EXT_RISE = 3'b110,
        CLK_EXT_FALL = 3'b111
    } clk_sel_t;

    typedef enum logic [1:0] {
        LOAD_NONE = 2'b00,
        LOAD_RISE = 2'b01,
        LOAD_FALL = 2'b10,
        LOAD_BOTH = 2'b11
    } load_edge_t;

    typedef struct packed {
        logic counter_overflow_flag;
        logic arbHigh;
        logic [2:0] level;
        logic bus_drive_select_b;
        logic bus_drive_select_a;
        load_edge_t loadEdge;
        clk_sel_t clkSel;
    } unit_ctl_t;

    typedef struct packed {
        logic [1:0] vecUpper;
        logic freezeResp;
        logic runBit;
        logic [2:0] arbField;
    } cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [15:0] data;
    } reg_req_t;

    typedef struct packed {
        logic req;
        logic [2:0] level;
        logic [3:0] arb;
        logic [7:0] vector;
    } irq_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic ovf;
    } step_t;

    typedef struct packed {
        logic [2:0] pinMeta;
        logic [2:0] pinSync;
        logic [2:0] pinPrev;
        unit_ctl_t freeCtl;
        unit_ctl_t modCtl;
        logic [15:0] freeCnt;
        logic [15:0] modCnt;
        logic [15:0] modLatch;
        cfg_t cfg;
        logic [PRESC_WIDTH-1:0] presc;
        logic freeBlock;
        logic modBlock;
        logic [15:0] rdData;
        logic [15:0] busA;
        logic [15:0] busB;
        irq_t irq;
    } state_t;

endpackage

`default_nettype wire

// ==== design/free_and_modulus_counter.sv ====
// Free-running and modulus counter units with prescaler, bus drive
// and interrupt request logic. Assumes one system clock, a same-clock
// register port and freeze/mask inputs, and asynchronous pins.
`default_nettype none
// How it works
// - 16-bit up counter, all-ones wrap sets overflow
// - Counter reads live value, writes load it
// - Reset clears free counter
// - Software zero write never raises overflow
// - Three-bit field picks one of eight sources
// - Source change ignores spurious pin edges
// - Count pin synchronised, level readable
// - No counting before prescaler run bit
// - External edges counted as events
// - Two drive bits choose time base bus
// - Nonzero level enables overflow request
// - Contend only above processor priority mask
// - Arbitration number from config plus high bit
// - Vector is upper bits plus unit number
// - Unused bits read zero, writes ignored
// - Modulus reload on overflow and load edge
// - Counter write loads counter and latch
// - Latch write changes latch only, readable
// - Reset clears modulus latch
// - Freeze with response bit stops counting
// - All-ones latch overflows every count
// - Zero latch behaves as free counter

module free_and_modulus_counter
    import free_and_modulus_counter_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // Register port
    input wire reg_req_t regReq,
    output logic [15:0] rdData,
    // Asynchronous pins
    input wire logic extCountIn,
    input wire logic modCountIn,
    input wire logic modLoadIn,
    // System signals from same-clock logic
    input wire logic freezeIn,
    input wire logic [2:0] ipMask,
    // Time base buses, wired-OR contributions
    output logic [15:0] busA,
    output logic [15:0] busB,
    // Interrupt request
    output irq_t irqOut
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Picks the count event for one unit
    function automatic logic sourceTick(input clk_sel_t sel,
            input logic [5:0] taps, input logic rise, input logic fall);
        logic t;
        t = 1'b0;
        case (sel)
            CLK_TAP1: t = taps[0];
            CLK_TAP2: t = taps[1];
            CLK_TAP3: t = taps[2];
            CLK_TAP4: t = taps[3];
            CLK_TAP5: t = taps[4];
            CLK_TAP6: t = taps[5];
            CLK_EXT_RISE: t = rise;
            CLK_EXT_FALL: t = fall;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // One counter step; write beats load beats count
    function automatic step_t unitStep(input logic [15:0] cnt,
            input logic [15:0] reload, input logic tick, input logic wr,
            input logic [15:0] wrData, input logic load);
        step_t s;
        s.cnt = cnt;
        s.ovf = 1'b0;
        if (wr) begin
            s.cnt = wrData;
        end else if (load) begin
            s.cnt = reload;
        end else if (tick) begin
            if (cnt == COUNT_ALL_ONES) begin
                s.ovf = 1'b1;
                s.cnt = reload;
            end else begin
                s.cnt = cnt + 16'h0001;
            end
        end
        return s;
    endfunction

    // Status/control register read image
    function automatic logic [15:0] ctlImage(input unit_ctl_t c,
            input logic pin, input logic loadPin);
        logic [15:0] v;
        v = 16'h0000;
        v[CTL_COF_BIT] = c.counter_overflow_flag;
        v[CTL_PIN_BIT] = pin;
        v[CTL_ARBHI_BIT] = c.arbHigh;
        v[CTL_LOADPIN_BIT] = loadPin;
        v[CTL_LEVEL_LSB +: 3] = c.level;
        v[CTL_BUS_DRIVE_SELECT_B_BIT] = c.bus_drive_select_b;
        v[CTL_BUS_DRIVE_SELECT_A_BIT] = c.bus_drive_select_a;
        v[CTL_LOADEDGE_LSB +: 2] = c.loadEdge;
        v[CTL_CLKSEL_LSB +: 3] = c.clkSel;
        return v;
    endfunction

    // Status/control write; overflow flag only cleared by a zero
    function automatic unit_ctl_t ctlWrite(input unit_ctl_t old,
            input logic [15:0] d, input logic hasLoad);
        unit_ctl_t c;
        c = old;
        c.counter_overflow_flag = old.counter_overflow_flag & d[CTL_COF_BIT];
        c.arbHigh = d[CTL_ARBHI_BIT];
        c.level = d[CTL_LEVEL_LSB +: 3];
        c.bus_drive_select_b = d[CTL_BUS_DRIVE_SELECT_B_BIT];
        c.bus_drive_select_a = d[CTL_BUS_DRIVE_SELECT_A_BIT];
        c.loadEdge = hasLoad ? load_edge_t'(d[CTL_LOADEDGE_LSB +: 2])
                : LOAD_NONE;
        c.clkSel = clk_sel_t'(d[CTL_CLKSEL_LSB +: 3]);
        return c;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_t st_reg;
    state_t st_next;

    logic running;
    logic [5:0] taps;
    logic [2:0] rise;
    logic [2:0] fall;
    logic freeTick;
    logic modTick;
    logic modLoad;
    logic wrFreeCnt;
    logic wrModCnt;
    logic wrLatch;
    logic wrFreeCtl;
    logic wrModCtl;
    logic freeReq;
    logic modReq;
    logic freeWins;
    step_t freeStep;
    step_t modStep;

    // Strobes, edges, taps and count qualifiers
    always_comb begin
        wrFreeCnt = regReq.wr && regReq.addr == REG_FREE_CNT;
        wrModCnt = regReq.wr && regReq.addr == REG_MOD_CNT;
        wrLatch = regReq.wr && regReq.addr == REG_MOD_LATCH;
        wrFreeCtl = regReq.wr && regReq.addr == REG_FREE_CTL;
        wrModCtl = regReq.wr && regReq.addr == REG_MOD_CTL;
        // Nothing counts before run, nor while frozen
        running = st_reg.cfg.runBit &&
                !(freezeIn && st_reg.cfg.freezeResp);
        // Edges come from the second synchroniser stage only
        rise = st_reg.pinSync & ~st_reg.pinPrev;
        fall = ~st_reg.pinSync & st_reg.pinPrev;
        // Constant-width mask: bits above k forced high, so low k+1 decide
        for (int k = 0; k < PRESC_WIDTH; k++) begin
            taps[k] = running && (&(st_reg.presc | (6'h3e << k)));
        end
        // Control write cycle and the one after ignore pin edges
        freeTick = running && !wrFreeCtl && !st_reg.freeBlock &&
                sourceTick(st_reg.freeCtl.clkSel, taps,
                rise[PIN_FREE_COUNT], fall[PIN_FREE_COUNT]);
        modTick = running && !wrModCtl && !st_reg.modBlock &&
                sourceTick(st_reg.modCtl.clkSel, taps,
                rise[PIN_MOD_COUNT], fall[PIN_MOD_COUNT]);
        modLoad = (st_reg.modCtl.loadEdge[0] && rise[PIN_MOD_LOAD]) ||
                (st_reg.modCtl.loadEdge[1] && fall[PIN_MOD_LOAD]);
        freeStep = unitStep(st_reg.freeCnt, COUNT_RESET, freeTick,
                wrFreeCnt, regReq.data, 1'b0);
        modStep = unitStep(st_reg.modCnt, st_reg.modLatch, modTick,
                wrModCnt, regReq.data, modLoad);
        // Request only if level nonzero and above the mask
        freeReq = st_reg.freeCtl.counter_overflow_flag && st_reg.freeCtl.level != 3'h0 &&
                st_reg.freeCtl.level > ipMask;
        modReq = st_reg.modCtl.counter_overflow_flag && st_reg.modCtl.level != 3'h0 &&
                st_reg.modCtl.level > ipMask;
        // Higher level wins inside the block; ties go to free unit
        freeWins = freeReq &&
                (!modReq || st_reg.freeCtl.level >= st_reg.modCtl.level);
    end

    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.pinMeta = {modLoadIn, modCountIn, extCountIn};
        st_next.pinSync = st_reg.pinMeta;
        st_next.pinPrev = st_reg.pinSync;
        st_next.freeBlock = wrFreeCtl;
        st_next.modBlock = wrModCtl;
        // Prescaler halts with the counters
        if (running) begin
            st_next.presc = st_reg.presc + 6'h01;
        end
        // Register writes
        if (wrFreeCtl) begin
            st_next.freeCtl = ctlWrite(st_reg.freeCtl, regReq.data, 1'b0);
        end
        if (wrModCtl) begin
            st_next.modCtl = ctlWrite(st_reg.modCtl, regReq.data, 1'b1);
        end
        if (regReq.wr && regReq.addr == REG_CONFIG) begin
            st_next.cfg.vecUpper = regReq.data[CFG_VECT_LSB +: 2];
            st_next.cfg.freezeResp = regReq.data[CFG_FRZ_BIT];
            st_next.cfg.runBit = regReq.data[CFG_RUN_BIT];
            st_next.cfg.arbField = regReq.data[CFG_ARB_LSB +: 3];
        end
        if (wrLatch || wrModCnt) begin
            st_next.modLatch = regReq.data;
        end
        st_next.freeCnt = freeStep.cnt;
        st_next.modCnt = modStep.cnt;
        // Overflow set wins over a clearing write
        if (freeStep.ovf) begin
            st_next.freeCtl.counter_overflow_flag = 1'b1;
        end
        if (modStep.ovf) begin
            st_next.modCtl.counter_overflow_flag = 1'b1;
        end
        // Read data, one cycle after the strobe
        st_next.rdData = 16'h0000;
        if (regReq.rd) begin
            case (regReq.addr)
                REG_FREE_CTL: st_next.rdData = ctlImage(st_reg.freeCtl,
                        st_reg.pinSync[PIN_FREE_COUNT], 1'b0);
                REG_FREE_CNT: st_next.rdData = st_reg.freeCnt;
                REG_MOD_CTL: st_next.rdData = ctlImage(st_reg.modCtl,
                        st_reg.pinSync[PIN_MOD_COUNT],
                        st_reg.pinSync[PIN_MOD_LOAD]);
                REG_MOD_CNT: st_next.rdData = st_reg.modCnt;
                REG_MOD_LATCH: st_next.rdData = st_reg.modLatch;
                REG_CONFIG: st_next.rdData = {8'h00, st_reg.cfg.vecUpper,
                        1'b0, st_reg.cfg.freezeResp, st_reg.cfg.runBit,
                        st_reg.cfg.arbField};
                default: st_next.rdData = 16'h0000;
            endcase
        end
        // Wired-OR time base contributions
        st_next.busA = (st_reg.freeCtl.bus_drive_select_a ? st_reg.freeCnt : 16'h0000) |
                (st_reg.modCtl.bus_drive_select_a ? st_reg.modCnt : 16'h0000);
        st_next.busB = (st_reg.freeCtl.bus_drive_select_b ? st_reg.freeCnt : 16'h0000) |
                (st_reg.modCtl.bus_drive_select_b ? st_reg.modCnt : 16'h0000);
        // Interrupt request, arbitration number and vector
        st_next.irq.req = freeReq || modReq;
        if (freeWins) begin
            st_next.irq.level = st_reg.freeCtl.level;
            st_next.irq.arb = {st_reg.freeCtl.arbHigh,
                    st_reg.cfg.arbField};
            st_next.irq.vector = {st_reg.cfg.vecUpper,
                    FREE_UNIT_NUM};
        end else if (modReq) begin
            st_next.irq.level = st_reg.modCtl.level;
            st_next.irq.arb = {st_reg.modCtl.arbHigh,
                    st_reg.cfg.arbField};
            st_next.irq.vector = {st_reg.cfg.vecUpper,
                    MOD_UNIT_NUM};
        end else begin
            st_next.irq = '0;
        end
    end

    // State register; all fields reset to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign rdData = st_reg.rdData;
    assign busA = st_reg.busA;
    assign busB = st_reg.busB;
    assign irqOut = st_reg.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence freeWrite;
        clkEn && wrFreeCnt;
    endsequence

    sequence freeWrap;
        clkEn && freeTick && !wrFreeCnt &&
                st_reg.freeCnt == COUNT_ALL_ONES;
    endsequence

    cof_on_wrap_a: assert property (freeWrap |=>
            st_reg.freeCtl.counter_overflow_flag && st_reg.freeCnt == 16'h0000)
        else $error("free overflow not flagged");

    zero_write_quiet_a: assert property (freeWrite ##0
            (!st_reg.freeCtl.counter_overflow_flag && !freeStep.ovf) |=> !st_reg.freeCtl.counter_overflow_flag)
        else $error("counter write raised overflow");

    live_read_a: assert property (clkEn && regReq.rd &&
            regReq.addr == REG_FREE_CNT |=> rdData == $past(st_reg.freeCnt))
        else $error("counter read not live value");

    run_gate_a: assert property (clkEn && !st_reg.cfg.runBit &&
            !wrFreeCnt |=> $stable(st_reg.freeCnt))
        else $error("counter moved before run");

    freeze_hold_a: assert property (clkEn && freezeIn &&
            st_reg.cfg.freezeResp && !wrModCnt && !modLoad
            |=> st_reg.modCnt == $past(st_reg.modCnt))
        else $error("modulus counter moved while frozen");

    single_step_a: assert property (clkEn && freeTick &&
            !wrFreeCnt && st_reg.freeCnt != COUNT_ALL_ONES
            |=> st_reg.freeCnt == $past(st_reg.freeCnt) + 16'h0001)
        else $error("counter did not step by one");

    mod_write_a: assert property (clkEn && wrModCnt |=>
            st_reg.modCnt == st_reg.modLatch &&
            st_reg.modLatch == $past(regReq.data))
        else $error("modulus write not applied to both");

    mod_reload_a: assert property (clkEn && modTick && !wrModCnt &&
            !modLoad && st_reg.modCnt == COUNT_ALL_ONES
            |=> st_reg.modCnt == $past(st_reg.modLatch) &&
            st_reg.modCtl.counter_overflow_flag)
        else $error("modulus reload missing");

    irq_gate_a: assert property (irqOut.req |->
            irqOut.level != 3'h0 && irqOut.level > $past(ipMask))
        else $error("request with disabled level");

    vector_form_a: assert property (irqOut.req |->
            irqOut.vector[5:0] == FREE_UNIT_NUM ||
            irqOut.vector[5:0] == MOD_UNIT_NUM)
        else $error("vector low bits wrong");

    // Control write cycle or the blocked cycle after it
    sequence freeCtlChange;
        clkEn && (wrFreeCtl || st_reg.freeBlock) && !wrFreeCnt;
    endsequence

    src_change_a: assert property (freeCtlChange |=>
            $stable(st_reg.freeCnt))
        else $error("counter moved during source change");

    arb_number_a: assert property (clkEn && (freeReq || modReq)
            |=> irqOut.req && irqOut.arb[2:0] == $past(st_reg.cfg.arbField))
        else $error("arbitration number wrong");

    bus_drive_a: assert property (clkEn && st_reg.freeCtl.bus_drive_select_a &&
            !st_reg.modCtl.bus_drive_select_a |=> busA == $past(st_reg.freeCnt))
        else $error("time base bus A wrong");

    latch_only_a: assert property (clkEn && wrLatch &&
            !modTick && !modLoad |=> $stable(st_reg.modCnt) &&
            st_reg.modLatch == $past(regReq.data))
        else $error("latch write disturbed counter");

    enable_hold_a: assert property (!clkEn |=>
            $stable(st_reg))
        else $error("state moved with enable low");

endmodule // free_and_modulus_counter

`default_nettype wire

// ==== sim/pin_event_source.sv ====
// Far-side model of a pin driver: issues a burst of pin pulses.
// Assumes the same system clock as the counter block; idles low.
`default_nettype none

module pin_event_source (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Burst command
    input wire logic start,
    input wire logic [7:0] count,
    // Pin
    output logic pinOut
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] left;
    logic [1:0] phase;

    // Two cycles high, two low: a quarter of the system clock at most
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 8'h00;
            phase <= 2'h0;
            pinOut <= 1'b0;
        end else if (start) begin
            left <= count;
            phase <= 2'h0;
        end else if (left != 8'h00) begin
            phase <= phase + 2'h1;
            pinOut <= (phase < 2'h2);
            if (phase == 2'h3) begin
                left <= left - 8'h01;
            end
        end
    end
endmodule // pin_event_source

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the free-running and modulus counter units.
// Assumes the register port contract and a pulse model on each pin.
`default_nettype none

module tb import free_and_modulus_counter_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic freezeIn = 1'b0;
    logic [2:0] ipMask = 3'h0;
    reg_req_t regReq = '0;
    logic [2:0] pinStart = 3'h0;
    logic [7:0] pinCount = 8'h00;
    logic [2:0] pins;
    logic [15:0] rdData;
    logic [15:0] busA;
    logic [15:0] busB;
    irq_t irqOut;
    int fail_count = 0;
    int checked = 0;
    localparam logic [15:0] MC = 16'h0096; // bus_drive_select_b, load on rise, pin rise

    // Clock, 40 ns period
    always #20 clk = ~clk;

    free_and_modulus_counter DUT (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
        .regReq(regReq), .rdData(rdData), .extCountIn(pins[0]),
        .modCountIn(pins[1]), .modLoadIn(pins[2]), .freezeIn(freezeIn),
        .ipMask(ipMask), .busA(busA), .busB(busB), .irqOut(irqOut));

    // One pulse source per pin: count, modulus count, modulus load
    for (genvar i = 0; i < 3; i++) begin : g_src
        pin_event_source src (.clk(clk), .rst_b(rst_b),
            .start(pinStart[i]), .count(pinCount), .pinOut(pins[i]));
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask

    // Idle cycle before each strobe so no signal is assigned twice a step
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk);
        regReq <= '0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
        @(posedge clk);
        regReq <= '0;
        #1 v = rdData;
    endtask

    task automatic rdck(input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        check(v, exp);
    endtask

    // Fixed wait: the source needs four cycles a pulse, sync needs four
    task automatic pulse(input int idx, input logic [7:0] n);
        @(posedge clk);
        pinCount <= n;
        pinStart[idx] <= 1'b1;
        @(posedge clk);
        pinStart[idx] <= 1'b0;
        repeat (4 * n + 8) @(posedge clk);
    endtask

    function automatic logic [15:0] ctl(input logic [2:0] lvl,
        input logic hi, input logic drB, input logic drA,
        input logic [1:0] e, input logic [2:0] s);
        return {2'b00, hi, 2'b00, lvl, drB, drA, e, 1'b0, s};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdck(REG_FREE_CNT, 16'h0000);
        rdck(REG_MOD_LATCH, 16'h0000);
        rdck(3'h6, 16'h0000);
        wr(3'h7, 16'hffff);
        rdck(3'h7, 16'h0000);
        repeat (40) @(posedge clk);
        rdck(REG_FREE_CNT, 16'h0000);
        wr(REG_CONFIG, 16'hffbd);
        rdck(REG_CONFIG, 16'h009d);
    endtask

    // Window of 8 tap periods plus port latency
    task automatic t_taps();
        logic [15:0] v;
        for (int k = 0; k < 6; k++) begin
            wr(REG_FREE_CTL, ctl(3'h0, 1'b0, 1'b0, 1'b0, 2'b00, 3'(k)));
            wr(REG_FREE_CNT, 16'h0000);
            repeat (8 << (k + 1)) @(posedge clk);
            rd(REG_FREE_CNT, v);
            check({15'h0, v >= 16'h7 && v <= 16'ha}, 16'h1);
        end
    endtask

    task automatic t_free_events();
        logic [15:0] c;
        c = ctl(3'h5, 1'b1, 1'b0, 1'b1, 2'b00, 3'h6);
        ipMask <= 3'h2;
        wr(REG_FREE_CTL, c | 16'h1030);
        rdck(REG_FREE_CTL, c);
        wr(REG_FREE_CNT, 16'hfffd);
        rdck(REG_FREE_CNT, 16'hfffd);
        check(busA, 16'hfffd);
        check(busB, 16'h0000);
        pulse(0, 3);
        rdck(REG_FREE_CNT, 16'h0000);
        rdck(REG_FREE_CTL, c | 16'h8000);
        check({15'h0, irqOut.req}, 16'h1);
        check({13'h0, irqOut.level}, 16'h5);
        check({12'h0, irqOut.arb}, 16'h000d);
        check({8'h0, irqOut.vector}, {8'h0, 2'b10, FREE_UNIT_NUM});
        ipMask <= 3'h5;
        repeat (3) @(posedge clk);
        check({15'h0, irqOut.req}, 16'h0);
        ipMask <= 3'h4;
        repeat (3) @(posedge clk);
        check({15'h0, irqOut.req}, 16'h1);
        wr(REG_FREE_CTL, ctl(3'h5, 1'b1, 1'b0, 1'b1, 2'b00, 3'h7));
        repeat (3) @(posedge clk);
        check({15'h0, irqOut.req}, 16'h0);
        pulse(0, 2);
        rdck(REG_FREE_CNT, 16'h0002);
    endtask

    task automatic t_zero_write();
        wr(REG_FREE_CNT, 16'hffff);
        wr(REG_FREE_CNT, 16'h0000);
        repeat (4) @(posedge clk);
        rdck(REG_FREE_CTL, ctl(3'h5, 1'b1, 1'b0, 1'b1, 2'b00, 3'h7));
        check({15'h0, irqOut.req}, 16'h0);
    endtask

    task automatic t_freeze();
        freezeIn <= 1'b1;
        pulse(0, 2);
        rdck(REG_FREE_CNT, 16'h0000);
        freezeIn <= 1'b0;
        pulse(0, 1);
        rdck(REG_FREE_CNT, 16'h0001);
        // Enable low: pin edges are lost, nothing moves
        clkEn <= 1'b0;
        pulse(0, 2);
        clkEn <= 1'b1;
        rdck(REG_FREE_CNT, 16'h0001);
    endtask

    task automatic t_modulus();
        wr(REG_MOD_CTL, MC);
        wr(REG_MOD_CNT, 16'hfffe);
        rdck(REG_MOD_LATCH, 16'hfffe);
        wr(REG_MOD_LATCH, 16'h1000);
        rdck(REG_MOD_CNT, 16'hfffe);
        rdck(REG_MOD_LATCH, 16'h1000);
        pulse(1, 2);
        rdck(REG_MOD_CNT, 16'h1000);
        check(busB, 16'h1000);
        check(busA, 16'h0001);
        rdck(REG_MOD_CTL, MC | 16'h8000);
        check({15'h0, irqOut.req}, 16'h0);
        // Level 6 above mask 4, overflow kept: modulus unit requests
        wr(REG_MOD_CTL, MC | 16'h8600);
        repeat (3) @(posedge clk);
        check({8'h0, irqOut.vector}, {8'h0, 2'b10, MOD_UNIT_NUM});
        check({12'h0, irqOut.arb}, 16'h0005);
        wr(REG_MOD_LATCH, 16'h2222);
        pulse(2, 1);
        rdck(REG_MOD_CNT, 16'h2222);
        wr(REG_MOD_CNT, 16'hffff);
        wr(REG_MOD_CTL, MC);
        pulse(1, 1);
        rdck(REG_MOD_CNT, 16'hffff);
        rdck(REG_MOD_CTL, MC | 16'h8000);
        wr(REG_MOD_CTL, MC);
        pulse(1, 1);
        rdck(REG_MOD_CTL, MC | 16'h8000);
        wr(REG_MOD_CNT, 16'hfffe);
        wr(REG_MOD_LATCH, 16'h0000);
        pulse(1, 3);
        rdck(REG_MOD_CNT, 16'h0001);
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence after a 12-cycle reset
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_taps();
        t_free_events();
        t_zero_write();
        t_freeze();
        t_modulus();
        complete_run();
    end

    // Tests take about 1400 cycles; cut off well beyond that
    initial begin
        #(40 * 20000);
        fail_count++;
        complete_run();
    end
endmodule // tb

`default_nettype wire
